// ---- rtl/pos_sched.sv ----
// Input sampling scheduler of a positioning unit, with an APB slave.
// Assumes field pins are asynchronous and driveDone comes from the
// pulse generator on mclk.
//
// What this block does
// - While moving, sample encoder zero pulse only after the near-point switch.
// - With motor stopped, read near-point switch before a home-return drive.
// - While moving, monitor the near-point switch throughout home return.
// - In program mode, take home and jog inputs only in standby after end.
// - In program mode, read a general input only when its instruction runs.
// - In program mode, continuously monitor inputs assigned by parameters.
// - In program mode, continuously monitor relay flags replacing command inputs; home and jog relays are taken only in standby after end.
// - Pick each general input's filter constant from its configured use.
// - Count manual pulse generator pulses correctly up to 2 kHz, in manual mode or after the end step.
// - Interrupt inputs exist only in the two-axis variant.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module pos_sched
   import pos_sched_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire pos_sched_pkg::apb_req_s apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic servo_ready_in,
   input wire logic servo_complete_in,
   input wire logic encoder_zero_pulse_in,
   input wire logic near_point_switch_in,
   input wire logic home_return_cmd_in,
   input wire logic jog_forward_in,
   input wire logic jog_reverse_in,
   input wire logic forward_limit_in,
   input wire logic reverse_limit_in,
   input wire logic stopIn,
   input wire logic [7:0] gpIn,
   input wire logic driveDone,
   output logic driveRun,
   output logic driveFwd,
   output logic homeMode,
   output logic driveFault,
   output logic [7:0] intrEvent
);
   import pos_sched_pkg::*;

   typedef struct packed {
      logic manual;
      logic progEnd;
      logic dir;
      logic [3:0] relay;
      logic [15:0] useMap;
      pins_s sync1;
      pins_s sync2;
      logic [7:0][11:0] filtCnt;
      logic [7:0] filt;
      logic [7:0] filtPrev;
      motion_e st;
      kind_e kind;
      logic fault;
      logic done;
      logic armed;
      logic dogAtStart;
      logic zeroPrev;
      logic [7:0] gpLat;
      logic [7:0] paramView;
      logic [15:0] mpgCnt;
      logic [31:0] prdata;
      logic [7:0] intrEvt;
   } state_s;

   state_s q;
   state_s d;
   pins_s pins;
   logic wr;
   logic known;
   logic startReq;
   logic homeReq;
   logic fwdReq;
   logic rvsReq;
   logic stopAll;
   logic moveFwd;
   logic limHit;
   logic mpgOn;
   logic found;
   logic [2:0] idx;

   ////////////////////////////////////////////////////////////////////////
   // Without the two-axis variant an interrupt code falls back to general.
   function automatic logic [1:0] effUse(input logic [1:0] u);
      effUse = (u == USE_INT && !TWO_AXIS) ? USE_GP : u;
   endfunction

   function automatic logic [11:0] filtLimit(input logic [1:0] u);
      case (u)
         USE_MPG: filtLimit = FILT_MPG_CYC;
         USE_INT: filtLimit = FILT_INT_CYC;
         default: filtLimit = FILT_GP_CYC;
      endcase
   endfunction

   assign pins = '{servoReady: servo_ready_in,
                   servoComplete: servo_complete_in,
                   zeroPulse: encoder_zero_pulse_in,
                   nearPoint: near_point_switch_in,
                   homeCmd: home_return_cmd_in,
                   jogFwd: jog_forward_in, jogRvs: jog_reverse_in,
                   fwdLimit: forward_limit_in, rvsLimit: reverse_limit_in,
                   stop: stopIn, gp: gpIn};

   assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign known = apbReq.paddr inside {OFF_CTRL, OFF_CMD, OFF_RELAY,
                                       OFF_USE, OFF_STAT, OFF_GPLAT,
                                       OFF_MPGCNT};
   assign idx = apbReq.pwdata[CMD_IDX +: 3];

   ////////////////////////////////////////////////////////////////////////
   // Command sources. Manual mode watches the pins at all times; program
   // mode takes home and jog, pins or relays, only in standby after the end step.
   always_comb begin
      if (q.manual) begin
         homeReq = q.sync2.homeCmd;
         fwdReq = q.sync2.jogFwd;
         rvsReq = q.sync2.jogRvs;
      end else begin
         homeReq = q.progEnd && (q.sync2.homeCmd || q.relay[RELAY_HOME]);
         fwdReq = q.progEnd && (q.sync2.jogFwd || q.relay[RELAY_FWD]);
         rvsReq = q.progEnd && (q.sync2.jogRvs || q.relay[RELAY_RVS]);
      end
      stopAll = q.sync2.stop || (!q.manual && q.relay[RELAY_STOP]);
      startReq = wr && apbReq.paddr == OFF_CMD && !q.manual &&
                 apbReq.pwdata[CMD_START];
      moveFwd = q.kind == K_JOGF || (q.kind == K_DRIVE && q.dir);
      limHit = moveFwd ? q.sync2.fwdLimit : q.sync2.rvsLimit;
      mpgOn = q.manual || q.progEnd;
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      d.intrEvt = '0;
      d.sync1 = pins;
      d.sync2 = q.sync1;
      d.filtPrev = q.filt;
      d.zeroPrev = q.sync2.zeroPulse;
      found = 1'b0;

      // Each general input is debounced with the constant of its use.
      for (int i = 0; i < 8; i++) begin
         if (q.sync2.gp[i] == q.filt[i]) begin
            d.filtCnt[i] = '0;
         end else if (q.filtCnt[i] >=
                      filtLimit(effUse(q.useMap[2*i +: 2])) - 12'h001) begin
            d.filt[i] = q.sync2.gp[i];
            d.filtCnt[i] = '0;
         end else begin
            d.filtCnt[i] = q.filtCnt[i] + 12'h001;
         end
         if (q.filt[i] && !q.filtPrev[i] && !q.manual &&
             effUse(q.useMap[2*i +: 2]) == USE_INT) begin
            d.intrEvt[i] = 1'b1;
         end
         // Only the lowest-numbered generator input counts, so two
         // inputs set to the same use cannot double the count.
         if (!found && effUse(q.useMap[2*i +: 2]) == USE_MPG) begin
            found = 1'b1;
            if (mpgOn && q.filt[i] && !q.filtPrev[i]) begin
               d.mpgCnt = q.mpgCnt + 16'h0001;
            end
         end
         if (!q.manual && q.useMap[2*i +: 2] == USE_PARAM) begin
            d.paramView[i] = q.filt[i];
         end
      end

      ////////////////////////////////////////////////////////////////////
      // Motion sequencing.
      unique case (q.st)
         ST_IDLE: begin
            if (startReq || homeReq || fwdReq || rvsReq) begin
               d.st = ST_PRE;
               d.fault = 1'b0;
               d.done = 1'b0;
               d.armed = 1'b0;
               d.kind = startReq ? K_DRIVE : homeReq ? K_HOME :
                        fwdReq ? K_JOGF : K_JOGR;
            end
         end
         ST_PRE: begin
            if (q.kind == K_HOME) begin
               d.dogAtStart = q.sync2.nearPoint;
            end
            if (!q.sync2.servoReady || limHit) begin
               d.st = ST_IDLE;
               d.fault = 1'b1;
            end else begin
               d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (q.kind == K_HOME && q.sync2.nearPoint) begin
               d.armed = 1'b1;
            end
            if (!q.sync2.servoReady || limHit) begin
               d.st = ST_POST;
               d.fault = 1'b1;
            end else if (stopAll) begin
               d.st = ST_POST;
            end else if (q.kind == K_HOME) begin
               if (q.armed && q.sync2.zeroPulse && !q.zeroPrev) begin
                  d.st = ST_POST;
               end
            end else if (q.kind == K_DRIVE) begin
               if (driveDone) begin
                  d.st = ST_POST;
               end
            end else if (q.kind == K_JOGF ? !fwdReq : !rvsReq) begin
               d.st = ST_POST;
            end
         end
         ST_POST: begin
            if (q.sync2.servoComplete) begin
               d.st = ST_IDLE;
               d.done = 1'b1;
            end
         end
      endcase

      ////////////////////////////////////////////////////////////////////
      // Register access. Read data is loaded in the setup cycle so that
      // it comes from a flop while the slave still answers with no wait.
      if (apbReq.psel && !apbReq.penable) begin
         unique case (apbReq.paddr)
            OFF_CTRL: d.prdata = {29'h0, q.dir, q.progEnd, q.manual};
            OFF_RELAY: d.prdata = {28'h0, q.relay};
            OFF_USE: d.prdata = {16'h0, q.useMap};
            OFF_STAT: d.prdata = {16'h0, q.filt, q.dogAtStart, q.armed,
                                  q.done, q.fault, q.kind, q.st};
            OFF_GPLAT: d.prdata = {16'h0, q.paramView, q.gpLat};
            OFF_MPGCNT: d.prdata = {16'h0, q.mpgCnt};
            default: d.prdata = 32'h0;
         endcase
      end
      if (wr) begin
         unique case (apbReq.paddr)
            OFF_CTRL: begin
               d.manual = apbReq.pwdata[CTRL_MANUAL];
               d.progEnd = apbReq.pwdata[CTRL_PROGEND];
               d.dir = apbReq.pwdata[CTRL_DIR];
            end
            OFF_RELAY: d.relay = apbReq.pwdata[3:0];
            OFF_USE: d.useMap = apbReq.pwdata[15:0];
            OFF_CMD: begin
               if (!q.manual && apbReq.pwdata[CMD_GPREAD]) begin
                  d.gpLat[idx] = q.filt[idx];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.manual <= CTRL_RST[CTRL_MANUAL];
         q.progEnd <= CTRL_RST[CTRL_PROGEND];
         q.dir <= CTRL_RST[CTRL_DIR];
         q.useMap <= USE_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign prdata = q.prdata;
   assign pready = 1'b1;
   assign pslverr = apbReq.psel && apbReq.penable && !known;
   assign driveRun = q.st == ST_RUN;
   assign driveFwd = moveFwd;
   assign homeMode = q.kind == K_HOME;
   assign driveFault = q.fault;
   assign intrEvent = q.intrEvt;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence homeRunUnarmed;
      q.st == ST_RUN && q.kind == K_HOME && !q.armed;
   endsequence

   sequence preFails;
      q.st == ST_PRE && !q.sync2.servoReady;
   endsequence

   zero_needs_dog_a: assert property (
      homeRunUnarmed ##0 !stopAll && q.sync2.servoReady && !limHit
      |=> q.st == ST_RUN)
      else $error("zero pulse taken before near point");

   dog_at_start_a: assert property (
      q.st == ST_PRE && q.kind == K_HOME
      |=> q.dogAtStart == $past(q.sync2.nearPoint))
      else $error("near point not read before home drive");

   arm_on_dog_a: assert property (
      q.st == ST_RUN && q.kind == K_HOME && q.sync2.nearPoint |=> q.armed)
      else $error("near point not watched during home");

   auto_gate_a: assert property (
      q.st == ST_IDLE && !q.manual && !q.progEnd && !startReq
      |=> q.st == ST_IDLE)
      else $error("command taken outside standby");

   gp_read_a: assert property (
      wr && apbReq.paddr == OFF_CMD && !q.manual &&
      apbReq.pwdata[CMD_GPREAD]
      |=> q.gpLat[$past(idx)] == $past(q.filt[idx]))
      else $error("general input not latched");

   param_view_a: assert property (
      !q.manual && q.useMap[5:4] == USE_PARAM |=>
      q.paramView[2] == $past(q.filt[2]))
      else $error("parameter input not monitored");

   pre_check_a: assert property (
      preFails |=> q.st == ST_IDLE && q.fault ##1 q.st != ST_RUN)
      else $error("drive started without servo ready");

   stop_run_a: assert property (
      q.st == ST_RUN && stopAll |=> q.st == ST_POST)
      else $error("stop ignored while running");

   post_wait_a: assert property (
      q.st == ST_POST && !q.sync2.servoComplete |=> q.st == ST_POST)
      else $error("left drive end without complete");

endmodule

// ---- include/pos_sched_pkg.sv ----
// Package for the positioning input sampling scheduler.
// Assumes a single 25 MHz clock and an APB master with 32-bit data.
package pos_sched_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_RELAY = 8'h08;
   localparam logic [7:0] OFF_USE = 8'h0C;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_GPLAT = 8'h14;
   localparam logic [7:0] OFF_MPGCNT = 8'h18;

   // Field positions.
   localparam int CTRL_MANUAL = 0;
   localparam int CTRL_PROGEND = 1;
   localparam int CTRL_DIR = 2;
   localparam int CMD_START = 0;
   localparam int CMD_GPREAD = 1;
   localparam int CMD_IDX = 4;
   localparam int RELAY_HOME = 0;
   localparam int RELAY_FWD = 1;
   localparam int RELAY_RVS = 2;
   localparam int RELAY_STOP = 3;

   // Reset values.
   localparam logic [2:0] CTRL_RST = 3'h1;
   localparam logic [15:0] USE_RST = 16'h0000;

   // Input use codes, two bits per general input.
   localparam logic [1:0] USE_GP = 2'h0;
   localparam logic [1:0] USE_MPG = 2'h1;
   localparam logic [1:0] USE_INT = 2'h2;
   localparam logic [1:0] USE_PARAM = 2'h3;

   // Variant: the two-axis unit has interrupt inputs.
   localparam logic TWO_AXIS = 1'b1;

   // Filter constants.
   localparam int CLK_MHZ = 25;
   localparam int FILT_GP_US = 100;
   localparam int FILT_MPG_US = 50;
   localparam int FILT_INT_US = 20;
   localparam logic [11:0] FILT_GP_CYC = 12'(FILT_GP_US * CLK_MHZ);
   localparam logic [11:0] FILT_MPG_CYC = 12'(FILT_MPG_US * CLK_MHZ);
   localparam logic [11:0] FILT_INT_CYC = 12'(FILT_INT_US * CLK_MHZ);

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_PRE = 2'h1,
      ST_RUN = 2'h3,
      ST_POST = 2'h2
   } motion_e;

   typedef enum logic [1:0] {
      K_DRIVE = 2'h0,
      K_HOME = 2'h1,
      K_JOGF = 2'h2,
      K_JOGR = 2'h3
   } kind_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic servoReady;
      logic servoComplete;
      logic zeroPulse;
      logic nearPoint;
      logic homeCmd;
      logic jogFwd;
      logic jogRvs;
      logic fwdLimit;
      logic rvsLimit;
      logic stop;
      logic [7:0] gp;
   } pins_s;

endpackage

// ---- tb/drive_model.sv ----
// Behavioural servo drive: ready line, in-position line, encoder zero pulse.
// Assumes driveRun and homeMode come from the scheduler on mclk.
`timescale 1ns/1ps
module drive_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic driveRun,
   input wire logic homeMode,
   input wire logic readyOk,
   input wire logic slow,
   output logic servo_ready_in,
   output logic servo_complete_in,
   output logic encoder_zero_pulse_in
);
   logic [7:0] settle;
   logic [4:0] phase;
   ////////////////////////////////////////////////////////////////////////
   // The bench drops ready on purpose to provoke a drive fault.
   assign servo_ready_in = readyOk;
   // A slow drive settles late, so the post-drive wait is really exercised.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         settle <= 8'h00;
         phase <= 5'h00;
         servo_complete_in <= 1'b0;
         encoder_zero_pulse_in <= 1'b0;
      end else begin
         if (driveRun) begin
            settle <= 8'h00;
         end else if (settle != 8'hFF) begin
            settle <= settle + 8'h01;
         end
         phase <= (driveRun && homeMode) ? phase + 5'h01 : 5'h00;
         servo_complete_in <= !driveRun && settle >= (slow ? 8'h60 : 8'h04);
         encoder_zero_pulse_in <= driveRun && homeMode && phase[4:3] == 2'h3;
      end
   end
endmodule

// ---- tb/pos_sched_bench.sv ----
// Self-checking bench of the input sampling scheduler.
// Assumes the drive model in its own file and the package constants.
`timescale 1ns/1ps
module pos_sched_bench;
   import pos_sched_pkg::*;
   logic mclk, rst_n, readyOk, slow, pready, pslverr, err, sr, sc, zp;
   logic nearPt, homeCmd, jogF, jogR, limF, limR, stopIn, driveDone;
   logic driveRun, driveFwd, homeMode, driveFault;
   logic [7:0] gpIn, intrEvent, v;
   logic [31:0] prdata, rd;
   logic [15:0] c0;
   apb_req_s apbReq;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   int intCnt = 0;
   int idx;
   ////////////////////////////////////////////////////////////////////////
   pos_sched uut (.mclk(mclk), .rst_n(rst_n), .apbReq(apbReq),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .servo_ready_in(sr), .servo_complete_in(sc),
      .encoder_zero_pulse_in(zp), .near_point_switch_in(nearPt),
      .home_return_cmd_in(homeCmd), .jog_forward_in(jogF),
      .jog_reverse_in(jogR), .forward_limit_in(limF),
      .reverse_limit_in(limR), .stopIn(stopIn), .gpIn(gpIn),
      .driveDone(driveDone), .driveRun(driveRun), .driveFwd(driveFwd),
      .homeMode(homeMode), .driveFault(driveFault), .intrEvent(intrEvent));
   drive_model partner (.mclk(mclk), .rst_n(rst_n), .driveRun(driveRun),
      .homeMode(homeMode), .readyOk(readyOk), .slow(slow),
      .servo_ready_in(sr), .servo_complete_in(sc),
      .encoder_zero_pulse_in(zp));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // The ceiling sits well above the longest filter sequence.
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (intrEvent[1] === 1'b1) intCnt = intCnt + 1;
      if (cycles == 90000) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   // Outputs are looked at on the falling edge, where they have settled.
   task automatic waitRun(input logic lvl);
      int k;
      k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (driveRun !== lvl && k < 400);
      @(posedge mclk);
   endtask
   function automatic logic [31:0] expStat(input logic [1:0] st,
      input logic [1:0] kd, input logic done);
      return {26'h0, done, 1'b0, kd, st};
   endfunction
   function automatic logic seen(input int wid, input logic [11:0] filt);
      return wid > int'(filt);
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {readyOk, slow, nearPt, homeCmd, jogF, jogR} = 6'h20;
      {limF, limR, stopIn, driveDone, rst_n} = 5'h00;
      gpIn = 8'h00;
      apbReq = '0;
      idx = $urandom(2);
      cyc(5);
      rst_n <= 1'b1;
      cyc(3);
      xfer(1'b0, OFF_CTRL, '0);
      chk(rd, 32'(CTRL_RST), "ctrl reset");
      xfer(1'b0, 8'h1C, '0);
      chk({rd[30:0], err}, 32'h1, "unmapped");
      // Program mode: refused starts, then a full drive with slow settle.
      wr(OFF_CTRL, 32'h4);
      readyOk <= 1'b0;
      wr(OFF_CMD, 32'h1);
      cyc(4);
      chk({driveRun, driveFault}, 32'h1, "ready fault");
      readyOk <= 1'b1;
      limF <= 1'b1;
      cyc(4);
      wr(OFF_CMD, 32'h1);
      cyc(4);
      chk({driveRun, driveFault}, 32'h1, "limit fault");
      limF <= 1'b0;
      slow <= 1'b1;
      wr(OFF_CMD, 32'h1);
      waitRun(1'b1);
      limR <= 1'b1;
      cyc(10);
      chk({driveRun, driveFwd}, 32'h3, "run fwd");
      limR <= 1'b0;
      driveDone <= 1'b1;
      cyc(1);
      driveDone <= 1'b0;
      waitRun(1'b0);
      xfer(1'b0, OFF_STAT, '0);
      chk(rd[5:0], expStat(2'h2, K_DRIVE, 1'b0), "post wait");
      cyc(120);
      xfer(1'b0, OFF_STAT, '0);
      chk(rd[5:0], expStat(2'h0, K_DRIVE, 1'b1), "done");
      slow <= 1'b0;
      wr(OFF_CMD, 32'h1);
      waitRun(1'b1);
      readyOk <= 1'b0;
      waitRun(1'b0);
      chk(driveFault, 1'b1, "ready lost");
      readyOk <= 1'b1;
      cyc(20);
      wr(OFF_CMD, 32'h1);
      waitRun(1'b1);
      stopIn <= 1'b1;
      waitRun(1'b0);
      chk(driveRun, 1'b0, "stop");
      stopIn <= 1'b0;
      cyc(20);
      // Jog is refused before the end step, taken in standby after it.
      jogF <= 1'b1;
      cyc(20);
      chk(driveRun, 1'b0, "jog refused");
      wr(OFF_CTRL, 32'h2);
      waitRun(1'b1);
      chk({driveRun, driveFwd}, 32'h3, "jog taken");
      jogF <= 1'b0;
      waitRun(1'b0);
      cyc(20);
      wr(OFF_RELAY, 32'h1 << RELAY_RVS);
      waitRun(1'b1);
      chk({driveRun, driveFwd}, 32'h2, "relay jog");
      wr(OFF_RELAY, 32'h0);
      waitRun(1'b0);
      chk(driveRun, 1'b0, "relay drop");
      cyc(20);
      // Home return: zero pulses are ignored until the near point is seen.
      wr(OFF_CTRL, 32'h1);
      for (int n = 0; n < 2; n++) begin
         homeCmd <= 1'b1;
         waitRun(1'b1);
         homeCmd <= 1'b0;
         chk({homeMode, driveFwd}, 32'h2, "home dir");
         if (n == 0) begin
            cyc(100);
            chk(driveRun, 1'b1, "zero early");
            nearPt <= 1'b1;
         end
         waitRun(1'b0);
         chk(driveRun, 1'b0, "home end");
         cyc(20);
         xfer(1'b0, OFF_STAT, '0);
         chk(rd[7], n[0], "dog at start");
      end
      nearPt <= 1'b0;
      // General input is read only when its instruction runs.
      wr(OFF_CTRL, 32'h0);
      v = 8'($urandom);
      idx = $urandom % 8;
      gpIn <= v;
      cyc(2600);
      wr(OFF_CMD, 32'(idx) << CMD_IDX | 32'h1 << CMD_GPREAD);
      gpIn <= ~v;
      cyc(2600);
      xfer(1'b0, OFF_GPLAT, '0);
      chk(rd[idx], v[idx], "gp latch");
      xfer(1'b0, OFF_STAT, '0);
      chk(rd[15:8], 8'(~v), "gp filtered");
      gpIn <= 8'h00;
      // Filter per use and generator counting at 2 kHz.
      wr(OFF_CTRL, 32'h1);
      wr(OFF_USE, 32'h39);
      cyc(2600);
      xfer(1'b0, OFF_MPGCNT, '0);
      c0 = rd[15:0];
      repeat (3) begin
         gpIn <= 8'h01;
         cyc(6250);
         gpIn <= 8'h00;
         cyc(6250);
      end
      xfer(1'b0, OFF_MPGCNT, '0);
      chk(rd, 32'(c0 + 16'h3), "mpg count");
      gpIn <= 8'h09;
      cyc(1500);
      xfer(1'b0, OFF_STAT, '0);
      chk(rd[11], seen(1500, FILT_GP_CYC), "gp short");
      gpIn <= 8'h00;
      cyc(1500);
      xfer(1'b0, OFF_MPGCNT, '0);
      chk(rd, 32'(c0 + 16'h3 + 16'(seen(1500, FILT_MPG_CYC))), "mpg short");
      // Interrupt and parameter inputs in program mode.
      wr(OFF_CTRL, 32'h0);
      c0 = 16'(intCnt);
      gpIn <= 8'h06;
      cyc(2600);
      chk(32'(intCnt) - 32'(c0), 32'(TWO_AXIS), "interrupt");
      xfer(1'b0, OFF_GPLAT, '0);
      chk(rd[10], 1'b1, "param view");
      gpIn <= 8'h00;
      cyc(600);
      // A reset in mid-drive must return the scheduler to idle.
      wr(OFF_CMD, 32'h1);
      waitRun(1'b1);
      rst_n <= 1'b0;
      cyc(2);
      chk(32'({driveRun, driveFault, intrEvent}), 32'h0, "reset outs");
      rst_n <= 1'b1;
      cyc(3);
      xfer(1'b0, OFF_STAT, '0);
      chk(rd[5:0], expStat(2'h0, K_DRIVE, 1'b0), "reset stat");
      conclude();
   end
endmodule
